// File: hdl/dmev_defines.svh
// Contract
// - Bits 23-16 pick the irq number that aborts the channel and sets abort flag.
// - Bits 15-8 pick the irq number that starts a channel transfer.
// - Writing one to bit 7 forces a transfer start; reads as zero. Here an abort in the same cycle suppresses the start.
// - Writing one to bit 6 aborts the transfer; reads as zero.
// - Bit 5 set: pattern match aborts and clears channel enable; clear: ignored.
// - Bit 4 set: selected start irq starts a cell transfer; clear: ignored. Here an abort in the same cycle suppresses the start.
// - Bit 3 set: selected abort irq aborts the transfer; clear: ignored.
// - Event control bits 31-24 and 2-0 read as zero.
// - Interrupt control bits 23-16 enable the eight flag sources.
// - Interrupt control bits 31-24 and 15-8 read as zero.
// - Flag bit 7 sets when source pointer equals source size.
// - Flag bit 6 sets when source pointer reaches half of source size.
// - Flag bit 5 sets when destination pointer equals destination size.
// - Flag bit 4 sets when destination pointer reaches half destination size.
// - Flag bit 3 sets on block complete or pattern match.
// - Flag bit 2 sets on each completed cell.
// - Flag bit 1 sets on irq abort; bit 0 on address error.
`ifndef DMEV_DEFINES_SVH
`define DMEV_DEFINES_SVH
`define DMEV_ECON_ADDR      12'h000
`define DMEV_INT_ADDR       12'h004
`define DMEV_ABT_SEL_LSB    16
`define DMEV_STA_SEL_LSB    8
`define DMEV_FORCE_BIT      7
`define DMEV_ABORT_BIT      6
`define DMEV_PATTERN_ABORT_ENABLE_BIT      5
`define DMEV_START_IRQ_ENABLE_BIT     4
`define DMEV_ABORT_IRQ_ENABLE_BIT     3
`define DMEV_IE_LSB         16
`define DMEV_SEL_RESET      8'hFF
`define DMEV_FLG_SDONE      7
`define DMEV_FLG_SHALF      6
`define DMEV_FLG_DDONE      5
`define DMEV_FLG_DHALF      4
`define DMEV_FLG_BLOCK      3
`define DMEV_FLG_CELL       2
`define DMEV_FLG_ABORT      1
`define DMEV_FLG_ADDR       0
`endif

// File: hdl/dmev_pkg.sv
package dmev_pkg;
	typedef logic [7:0] dmev_irq_num_t;
	typedef logic [7:0] dmev_flags_t;
	typedef logic [15:0] dmev_size_t;
endpackage

// File: hdl/dmev_flag_bank.sv
`timescale 1ns/100ps
`default_nettype none
// Sticky flags: software clears by writing zero, a same-cycle hardware set wins.
module dmev_flag_bank
	import dmev_pkg::*;
#(
	parameter int NUM_FLAGS = 8
)
(
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	// Set, clear and enable
	input  wire logic [NUM_FLAGS-1:0] set_i,
	input  wire logic [NUM_FLAGS-1:0] clr_i,
	input  wire logic [NUM_FLAGS-1:0] enable_i,
	// State
	output logic      [NUM_FLAGS-1:0] flags_o,
	output logic                      irq_o
);
	logic [NUM_FLAGS-1:0] flag_reg;
	logic [NUM_FLAGS-1:0] flag_next;
	logic                 irq_reg;
	logic                 irq_next;

	genvar g;
	generate
		for (g = 0; g < NUM_FLAGS; g++)
		begin : g_flag
			always_comb
			begin
				flag_next[g] = set_i[g] | (flag_reg[g] & ~clr_i[g]);
			end
		end
	endgenerate

	always_comb
	begin
		irq_next = |(flag_next & enable_i);
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			flag_reg <= '0;
			irq_reg  <= 1'b0;
		end
		else
		begin
			flag_reg <= flag_next;
			irq_reg  <= irq_next;
		end
	end

	assign flags_o = flag_reg;
	assign irq_o   = irq_reg;
endmodule
`default_nettype wire

// File: hdl/dmev_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dmev_defines.svh"
module dmev_top
(
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Peripheral interrupt lines, one per irq number
	input  wire logic [255:0]         periph_irq_i,
	// Transfer engine status
	input  wire logic                 channel_on_bit_i,
	input  wire logic                 pattern_match_i,
	input  wire logic                 cell_xfer_done_i,
	input  wire logic                 block_xfer_done_i,
	input  wire logic                 addr_error_i,
	input  wire dmev_pkg::dmev_size_t source_pointer_i,
	input  wire dmev_pkg::dmev_size_t source_size_i,
	input  wire dmev_pkg::dmev_size_t dest_pointer_i,
	input  wire dmev_pkg::dmev_size_t dest_size_i,
	// Transfer engine control
	output logic                      start_xfer_o,
	output logic                      abort_xfer_o,
	output logic                      channel_off_o,
	output logic                      irq_o
);
	import dmev_pkg::*;

	dmev_irq_num_t abort_irq_select_reg;
	dmev_irq_num_t abort_irq_select_next;
	dmev_irq_num_t start_irq_select_reg;
	dmev_irq_num_t start_irq_select_next;
	logic          pattern_abort_enable_reg;
	logic          pattern_abort_enable_next;
	logic          start_irq_enable_reg;
	logic          start_irq_enable_next;
	logic          abort_irq_enable_reg;
	logic          abort_irq_enable_next;
	dmev_flags_t   ie_reg;
	dmev_flags_t   ie_next;
	logic [31:0]   prdata_reg;
	logic [31:0]   prdata_next;
	logic          start_reg;
	logic          start_next;
	logic          abort_reg;
	logic          abort_next;
	logic          off_reg;
	logic          off_next;
	logic          sptr_eq_reg;
	logic          sptr_half_reg;
	logic          dptr_eq_reg;
	logic          dptr_half_reg;
	logic          sptr_eq_next;
	logic          sptr_half_next;
	logic          dptr_eq_next;
	logic          dptr_half_next;
	dmev_flags_t   flag_set;
	dmev_flags_t   flag_clr;
	dmev_flags_t   flags;
	logic          flag_irq;
	logic          wr_access;
	logic          rd_access;
	logic          irq_abort_hit;
	logic          irq_start_hit;
	logic          pattern_abort;

	// Single-cycle access phase: the slave never inserts wait states.
	always_comb
	begin
		wr_access = psel & penable & pwrite;
		rd_access = psel & penable & ~pwrite;
	end

	always_comb
	begin
		irq_abort_hit = abort_irq_enable_reg & periph_irq_i[abort_irq_select_reg];
		irq_start_hit = start_irq_enable_reg & periph_irq_i[start_irq_select_reg];
		pattern_abort = pattern_abort_enable_reg & pattern_match_i;
	end

	// Configuration registers.
	always_comb
	begin
		abort_irq_select_next     = abort_irq_select_reg;
		start_irq_select_next     = start_irq_select_reg;
		pattern_abort_enable_next = pattern_abort_enable_reg;
		start_irq_enable_next     = start_irq_enable_reg;
		abort_irq_enable_next     = abort_irq_enable_reg;
		ie_next                   = ie_reg;
		if (wr_access && paddr == `DMEV_ECON_ADDR)
		begin
			abort_irq_select_next     = pwdata[`DMEV_ABT_SEL_LSB +: 8];
			start_irq_select_next     = pwdata[`DMEV_STA_SEL_LSB +: 8];
			pattern_abort_enable_next = pwdata[`DMEV_PATTERN_ABORT_ENABLE_BIT];
			start_irq_enable_next     = pwdata[`DMEV_START_IRQ_ENABLE_BIT];
			abort_irq_enable_next     = pwdata[`DMEV_ABORT_IRQ_ENABLE_BIT];
		end
		if (wr_access && paddr == `DMEV_INT_ADDR)
		begin
			ie_next = pwdata[`DMEV_IE_LSB +: 8];
		end
	end

	// Start and abort pulses towards the engine.
	always_comb
	begin
		start_next = irq_start_hit
			| (wr_access && paddr == `DMEV_ECON_ADDR && pwdata[`DMEV_FORCE_BIT]);
		abort_next = irq_abort_hit | pattern_abort
			| (wr_access && paddr == `DMEV_ECON_ADDR && pwdata[`DMEV_ABORT_BIT]);
		off_next   = pattern_abort & channel_on_bit_i;
		// Abort overrides a start seen in the same cycle.
		if (abort_next)
		begin
			start_next = 1'b0;
		end
	end

	// Pointer comparisons are registered so the flags set on the first cycle of a match only.
	always_comb
	begin
		sptr_eq_next   = source_pointer_i == source_size_i;
		sptr_half_next = source_pointer_i == (source_size_i >> 1);
		dptr_eq_next   = dest_pointer_i == dest_size_i;
		dptr_half_next = dest_pointer_i == (dest_size_i >> 1);
	end

	always_comb
	begin
		flag_set                  = '0;
		flag_set[`DMEV_FLG_SDONE] = sptr_eq_next & ~sptr_eq_reg;
		flag_set[`DMEV_FLG_SHALF] = sptr_half_next & ~sptr_half_reg;
		flag_set[`DMEV_FLG_DDONE] = dptr_eq_next & ~dptr_eq_reg;
		flag_set[`DMEV_FLG_DHALF] = dptr_half_next & ~dptr_half_reg;
		flag_set[`DMEV_FLG_BLOCK] = block_xfer_done_i | pattern_match_i;
		flag_set[`DMEV_FLG_CELL]  = cell_xfer_done_i;
		flag_set[`DMEV_FLG_ABORT] = irq_abort_hit;
		flag_set[`DMEV_FLG_ADDR]  = addr_error_i;
		flag_clr = '0;
		if (wr_access && paddr == `DMEV_INT_ADDR)
		begin
			flag_clr = ~pwdata[7:0];
		end
	end

	dmev_flag_bank #(
		.NUM_FLAGS (8)
	) u_flags (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.set_i     (flag_set),
		.clr_i     (flag_clr),
		.enable_i  (ie_next),
		.flags_o   (flags),
		.irq_o     (flag_irq)
	);

	// Read data; unused and write-only bits read zero.
	always_comb
	begin
		prdata_next = '0;
		if (psel && !penable && !pwrite)
		begin
			if (paddr == `DMEV_ECON_ADDR)
			begin
				prdata_next[`DMEV_ABT_SEL_LSB +: 8] = abort_irq_select_reg;
				prdata_next[`DMEV_STA_SEL_LSB +: 8] = start_irq_select_reg;
				prdata_next[`DMEV_PATTERN_ABORT_ENABLE_BIT]        = pattern_abort_enable_reg;
				prdata_next[`DMEV_START_IRQ_ENABLE_BIT]       = start_irq_enable_reg;
				prdata_next[`DMEV_ABORT_IRQ_ENABLE_BIT]       = abort_irq_enable_reg;
			end
			else if (paddr == `DMEV_INT_ADDR)
			begin
				prdata_next[`DMEV_IE_LSB +: 8] = ie_reg;
				prdata_next[7:0]               = flags;
			end
		end
		else if (rd_access)
		begin
			prdata_next = prdata_reg;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			abort_irq_select_reg     <= `DMEV_SEL_RESET;
			start_irq_select_reg     <= `DMEV_SEL_RESET;
			pattern_abort_enable_reg <= 1'b0;
			start_irq_enable_reg     <= 1'b0;
			abort_irq_enable_reg     <= 1'b0;
			ie_reg                   <= '0;
			prdata_reg               <= '0;
			start_reg                <= 1'b0;
			abort_reg                <= 1'b0;
			off_reg                  <= 1'b0;
			sptr_eq_reg              <= 1'b1;
			sptr_half_reg            <= 1'b1;
			dptr_eq_reg              <= 1'b1;
			dptr_half_reg            <= 1'b1;
		end
		else
		begin
			abort_irq_select_reg     <= abort_irq_select_next;
			start_irq_select_reg     <= start_irq_select_next;
			pattern_abort_enable_reg <= pattern_abort_enable_next;
			start_irq_enable_reg     <= start_irq_enable_next;
			abort_irq_enable_reg     <= abort_irq_enable_next;
			ie_reg                   <= ie_next;
			prdata_reg               <= prdata_next;
			start_reg                <= start_next;
			abort_reg                <= abort_next;
			off_reg                  <= off_next;
			sptr_eq_reg              <= sptr_eq_next;
			sptr_half_reg            <= sptr_half_next;
			dptr_eq_reg              <= dptr_eq_next;
			dptr_half_reg            <= dptr_half_next;
		end
	end

	assign prdata        = prdata_reg;
	assign pready        = 1'b1;
	assign pslverr       = 1'b0;
	assign start_xfer_o  = start_reg;
	assign abort_xfer_o  = abort_reg;
	assign channel_off_o = off_reg;
	assign irq_o         = flag_irq;
endmodule
`default_nettype wire

// File: testbench/dmev_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module dmev_engine_model
(
	// Clock and block control
	input  wire logic        sys_clk_i,
	input  wire logic        chan_off_i,
	// Irq lines and engine status
	output logic [255:0]     irq_o,
	output logic [3:0]       evt_o,
	output logic             chan_on_o,
	output dmev_pkg::dmev_size_t ptr_o,
	output dmev_pkg::dmev_size_t size_o,
	output dmev_pkg::dmev_size_t dptr_o,
	output dmev_pkg::dmev_size_t dsize_o
);
	import dmev_pkg::*;
	initial
	begin
		irq_o = '0;
		evt_o = '0;
		chan_on_o = 1'b1;
		ptr_o = 16'h0001;
		size_o = 16'h0008;
		dptr_o = 16'h0001;
		dsize_o = 16'h0008;
	end
	always @(posedge sys_clk_i)
		if (chan_off_i)
			chan_on_o <= 1'b0;
	// Callers only pulse lines of supported trigger sources.
	task pulse_irq(input int n);
		@(posedge sys_clk_i);
		irq_o[n] <= 1'b1;
		@(posedge sys_clk_i);
		irq_o[n] <= 1'b0;
	endtask
	task pulse_evt(input logic [3:0] e);
		@(posedge sys_clk_i);
		evt_o <= e;
		@(posedge sys_clk_i);
		evt_o <= 4'h0;
	endtask
	task set_ptr(input dmev_size_t p, input dmev_size_t dp);
		@(posedge sys_clk_i);
		ptr_o <= p;
		dptr_o <= dp;
	endtask
	task set_size(input dmev_size_t s, input dmev_size_t ds);
		@(posedge sys_clk_i);
		size_o <= s;
		dsize_o <= ds;
	endtask
endmodule
`default_nettype wire

// File: testbench/dmev_props.sv
`timescale 1ns/100ps
`default_nettype none
module dmev_props
(
	// Clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         rst_n_i,
	// Watched ports
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic         pready,
	input  wire logic         pslverr,
	input  wire logic [255:0] periph_irq_i,
	input  wire logic         channel_on_bit_i,
	input  wire logic         pattern_match_i,
	input  wire logic         start_xfer_o,
	input  wire logic         abort_xfer_o,
	input  wire logic         irq_o
);
	logic [31:0] econ_reg;
	logic [31:0] econ_next;
	logic        wr_e;
	logic        wr_i;
	logic        abt_any;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Shadow of the event control word so causes can be named without peeking inside.
	always_comb
	begin
		wr_e = psel && penable && pwrite && paddr == 12'h000;
		wr_i = psel && penable && pwrite && paddr == 12'h004;
		econ_next = wr_e ? pwdata : econ_reg;
		abt_any = (wr_e && pwdata[6]) || (econ_reg[3] && periph_irq_i[econ_reg[23:16]])
			|| (econ_reg[5] && pattern_match_i);
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			econ_reg <= 32'h00ff_ff00;
		else
			econ_reg <= econ_next;
	sequence s_sta_irq;
		econ_reg[4] && periph_irq_i[econ_reg[15:8]];
	endsequence
	sequence s_ie_off;
		wr_i && pwdata[23:16] == 8'h00;
	endsequence
	property p_bus; pready && !pslverr; endproperty
	property p_force; wr_e && pwdata[7] && !abt_any |=> start_xfer_o; endproperty
	property p_abort_transfer; wr_e && pwdata[6] |=> abort_xfer_o; endproperty
	property p_sirq; s_sta_irq ##0 !abt_any |=> start_xfer_o; endproperty
	property p_nostart; !(wr_e && pwdata[7]) && !(econ_reg[4] && periph_irq_i[econ_reg[15:8]]) |=> !start_xfer_o;
	endproperty
	property p_airq; econ_reg[3] && periph_irq_i[econ_reg[23:16]] |=> abort_xfer_o; endproperty
	property p_noabort; !abt_any |=> !abort_xfer_o; endproperty
	property p_pat; econ_reg[5] && pattern_match_i && channel_on_bit_i |=> abort_xfer_o; endproperty
	property p_irqoff; s_ie_off |=> ##1 !irq_o; endproperty
	a_bus: assert property (p_bus) else $error("bus answer wrong");
	a_force: assert property (p_force) else $error("no forced start");
	a_abort_transfer: assert property (p_abort_transfer) else $error("no written abort");
	a_sirq: assert property (p_sirq) else $error("no irq start");
	a_nostart: assert property (p_nostart) else $error("start without cause");
	a_airq: assert property (p_airq) else $error("no irq abort");
	a_noabort: assert property (p_noabort) else $error("abort without cause");
	a_pat: assert property (p_pat) else $error("no pattern abort");
	a_irqoff: assert property (p_irqoff) else $error("irq with enables off");
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import dmev_pkg::*;
	localparam logic [11:0] ECON = 12'h000;
	localparam logic [11:0] INTC = 12'h004;
	logic         sys_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, q;
	logic [255:0] irqs;
	logic [3:0]   evt;
	logic         chan_on, start_x, abort_x, chan_off, irq;
	dmev_size_t   ptr, size, dptr, dsize;
	int           errors, n_tests;
	dmev_top DUT(.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_irq_i(irqs), .channel_on_bit_i(chan_on), .pattern_match_i(evt[3]), .cell_xfer_done_i(evt[2]),
		.block_xfer_done_i(evt[1]), .addr_error_i(evt[0]), .source_pointer_i(ptr), .source_size_i(size),
		.dest_pointer_i(dptr), .dest_size_i(dsize), .start_xfer_o(start_x), .abort_xfer_o(abort_x),
		.channel_off_o(chan_off), .irq_o(irq));
	dmev_engine_model u_eng(.sys_clk_i(sys_clk_i), .chan_off_i(chan_off), .irq_o(irqs), .evt_o(evt),
		.chan_on_o(chan_on), .ptr_o(ptr), .size_o(size), .dptr_o(dptr), .dsize_o(dsize));
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		@(posedge sys_clk_i);
		for (k = 0; k < 16 && pready !== 1'b1; k++) @(posedge sys_clk_i);
		if (k == 16)
			errors++;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task t_regs;
		apb(0, ECON, 0);
		chk("econ rst", q, 32'h00ff_ff00);
		apb(0, INTC, 0);
		chk("int rst", q, 32'h0000_0000);
		apb(1, 12'h008, 32'hffff_ffff);
		apb(0, 12'h008, 0);
		chk("unmapped", q, 32'h0000_0000);
		apb(1, ECON, 32'hffff_ffff);
		apb(0, ECON, 0);
		chk("econ rb", q, 32'h00ff_ff38);
		apb(1, INTC, 32'hffff_ff00);
		apb(0, INTC, 0);
		chk("int rb", q, 32'h00ff_0000);
	endtask
	task t_events;
		apb(1, ECON, 32'h0005_0918);
		u_eng.pulse_irq(9);
		#1 chk("start", start_x, 1);
		chk("stray abort", abort_x, 0);
		u_eng.pulse_irq(5);
		#1 chk("abort", abort_x, 1);
		apb(0, INTC, 0);
		chk("abort flag", q[1], 1);
		apb(1, ECON, 32'h0005_0900);
		u_eng.pulse_irq(9);
		#1 chk("start off", start_x, 0);
		u_eng.pulse_irq(5);
		#1 chk("abort off", abort_x, 0);
		for (int i = 0; i < 256; i += 255)
		begin
			apb(1, ECON, {16'h0000, i[7:0], 8'h10});
			u_eng.pulse_irq(i);
			#1 chk("sel edge", start_x, 1);
		end
		apb(1, ECON, 32'h0000_0080);
		#1 chk("force", start_x, 1);
		apb(1, ECON, 32'h0000_0040);
		#1 chk("abort_transfer", abort_x, 1);
		apb(1, ECON, 32'h0000_0020);
		u_eng.pulse_evt(4'h8);
		#1 chk("pat abort", abort_x, 1);
		chk("chan off", chan_off, 1);
		apb(1, ECON, 0);
		u_eng.pulse_evt(4'h8);
		#1 chk("pat off", abort_x, 0);
	endtask
	task t_flags;
		apb(1, INTC, 0);
		u_eng.pulse_evt(4'h7);
		apb(0, INTC, 0);
		chk("evt flags", q, 32'h0000_000d);
		chk("irq masked", irq, 0);
		apb(1, INTC, 32'h0004_000d);
		apb(0, INTC, 0);
		chk("keep", q, 32'h0004_000d);
		chk("irq on", irq, 1);
		apb(1, INTC, 32'h0004_0009);
		apb(0, INTC, 0);
		chk("clear", q, 32'h0004_0009);
		chk("irq off", irq, 0);
		u_eng.set_ptr(4, 4);
		apb(0, INTC, 0);
		apb(0, INTC, 0);
		chk("half", q, 32'h0004_0059);
		u_eng.set_ptr(8, 8);
		apb(0, INTC, 0);
		apb(0, INTC, 0);
		chk("done", q, 32'h0004_00f9);
		// Only the source size moves, so only the source half flag may rise.
		apb(1, INTC, 32'h0004_0000);
		u_eng.set_size(16'h0010, 16'h0008);
		apb(0, INTC, 0);
		apb(0, INTC, 0);
		chk("src half only", q, 32'h0004_0040);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		sys_clk_i = 0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	initial
	begin
		{rst_n_i, psel, penable, pwrite, paddr, pwdata, errors, n_tests} = '0;
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_regs;
		t_events;
		t_flags;
		end_sim;
	end
	initial
	begin
		repeat (3000) @(posedge sys_clk_i);
		errors++;
		end_sim;
	end
endmodule
bind dmev_top dmev_props u_props(.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.periph_irq_i(periph_irq_i), .channel_on_bit_i(channel_on_bit_i), .pattern_match_i(pattern_match_i),
	.start_xfer_o(start_xfer_o), .abort_xfer_o(abort_xfer_o), .irq_o(irq_o));
`default_nettype wire
